// *** hdl/pio_pkg.sv ***
// Package for the parallel I/O pin controller: register map and reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses on ADR_I[7:0].
package pio_pkg;

    localparam int         PIO_WIDTH = 32;

    // Register byte offsets
    localparam logic [7:0] PIO_OFS_PIN_ENABLE     = 8'h00;
    localparam logic [7:0] PIO_OFS_PIN_DISABLE    = 8'h04;
    localparam logic [7:0] PIO_OFS_PIN_STATUS     = 8'h08;
    localparam logic [7:0] PIO_OFS_OUT_ENABLE     = 8'h10;
    localparam logic [7:0] PIO_OFS_OUT_DISABLE    = 8'h14;
    localparam logic [7:0] PIO_OFS_OUT_STATUS     = 8'h18;
    localparam logic [7:0] PIO_OFS_SET_OUTPUT     = 8'h30;
    localparam logic [7:0] PIO_OFS_CLEAR_OUTPUT   = 8'h34;
    localparam logic [7:0] PIO_OFS_OUT_DATA       = 8'h38;
    localparam logic [7:0] PIO_OFS_PIN_LEVEL      = 8'h3C;
    localparam logic [7:0] PIO_OFS_IRQ_ENABLE     = 8'h40;
    localparam logic [7:0] PIO_OFS_IRQ_DISABLE    = 8'h44;
    localparam logic [7:0] PIO_OFS_IRQ_MASK       = 8'h48;
    localparam logic [7:0] PIO_OFS_CHANGE_STATUS  = 8'h4C;
    localparam logic [7:0] PIO_OFS_PULLUP_DISABLE = 8'h60;
    localparam logic [7:0] PIO_OFS_PULLUP_ENABLE  = 8'h64;
    localparam logic [7:0] PIO_OFS_PULLUP_STATUS  = 8'h68;

    // Reset values
    localparam logic [31:0] PIO_RST_PIN_ENABLE = 32'h0000_0000;
    localparam logic [31:0] PIO_RST_OUT_ENABLE = 32'h0000_0000;
    localparam logic [31:0] PIO_RST_OUT_DATA   = 32'h0000_0000;
    localparam logic [31:0] PIO_RST_IRQ_MASK   = 32'h0000_0000;
    localparam logic [31:0] PIO_RST_PULLUP     = 32'hFFFF_FFFF;
    // Idle pins sit high under the reset pull-ups
    localparam logic [31:0] PIO_RST_PIN_LEVEL  = 32'hFFFF_FFFF;
    localparam logic [31:0] PIO_RST_ZERO       = 32'h0000_0000;

endpackage

// *** hdl/pio_bitreg.sv ***
// Set/clear register: one flop per pin, written through set and clear masks.
// Assumes the caller never sets and clears the same bit in one cycle.
`timescale 1ns/10ps
`default_nettype none

module pio_bitreg #(
    parameter logic [31:0] RESET_VALUE = pio_pkg::PIO_RST_ZERO
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Masks, ones act
    input  wire logic [31:0] set_mask,
    input  wire logic [31:0] clr_mask,
    // State
    output logic      [31:0] q
);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= RESET_VALUE;
        end else begin
            q <= (q | set_mask) & ~clr_mask;
        end
    end

endmodule

`default_nettype wire

// *** hdl/pio_ctrl.sv ***
// Parallel I/O pin controller for a 32-pin port, Wishbone classic slave.
// Assumes pad inputs synchronous to CLK; CLK is the gated peripheral clock.
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// (RULE1) Each pin goes to its peripheral or to generic I/O; enable write takes it.
// (RULE2) Generic pins: software drives output level and reads pin level back.
// (RULE3) Every pin has its own pull-up; all pull-ups on after reset.
// (RULE4) Pull-up disable write turns off only the written pins.
// (RULE5) Output enable write makes pins outputs; output disable makes them inputs.
// (RULE6) Set-output write drives pins high; clear-output write drives pins low.
// (RULE7) Read-only pin level register returns the current level on every pin.
// (RULE8) Level change on a pin raises the interrupt when that pin is enabled.
// (RULE9) Rising and falling changes both count as change events.
// (RULE10) Interrupt enable write enables change interrupts for written pins.
// (RULE11) Change status reports pins changed since its last read.
// (RULE12) Reading change status acknowledges the interrupt and clears changes.
// (RULE13) Interrupt is a level held until acknowledged; sink treats it as level.
// (RULE14) Software enables the peripheral clock before relying on sampling.
// (RULE15) Zero bits in set/clear/enable/disable writes do nothing; one bit per pin.
module pio_ctrl (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Wishbone classic slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Pads
    input  wire logic [31:0] PAD_IN,
    output logic      [31:0] PAD_OUT,
    output logic      [31:0] PAD_OE,
    output logic      [31:0] PULLUP_EN,
    // Peripheral side
    input  wire logic [31:0] PERIPH_OUT,
    input  wire logic [31:0] PERIPH_OE,
    output logic      [31:0] PERIPH_IN,
    // Interrupt
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic        ack_r;
    logic [31:0] dat_r;
    logic        irq_r;
    logic [31:0] pad_out_r;
    logic [31:0] pad_oe_r;
    logic [31:0] pin_level_r;
    logic [31:0] change_r;
    logic [31:0] change_nxt;
    logic [31:0] change_evt;
    logic [31:0] pin_en_q;
    logic [31:0] oe_q;
    logic [31:0] out_q;
    logic [31:0] mask_q;
    logic [31:0] pullup_q;
    logic [31:0] wmask;
    logic        req;
    logic        wr;
    logic        rd;
    logic        clr_status;
    logic [31:0] rd_data;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    function automatic logic [31:0] wr_mask(input logic sel_wr, input logic [31:0] m);
        wr_mask = sel_wr ? m : 32'h0000_0000;
    endfunction

    // New request only while no ack is out, so a held request acts once
    assign req   = CYC_I & STB_I & ~ack_r;
    assign wr    = req & WE_I;
    assign rd    = req & ~WE_I;
    assign wmask = DAT_I & {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    assign clr_status = rd & hit(ADR_I, pio_pkg::PIO_OFS_CHANGE_STATUS); // RULE12

    ////////////////////////////////////////////////////////////////////////////////
    // Set/clear registers

    logic [31:0] pin_en_set, pin_en_clr, oe_set, oe_clr, od_set, od_clr;
    logic [31:0] mask_set, mask_clr, pu_set, pu_clr;

    assign pin_en_set = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_PIN_ENABLE), wmask);    // RULE1
    assign pin_en_clr = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_PIN_DISABLE), wmask);   // RULE15
    assign oe_set     = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_OUT_ENABLE), wmask);    // RULE5
    assign oe_clr     = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_OUT_DISABLE), wmask);   // RULE5
    assign od_set     = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_SET_OUTPUT), wmask);    // RULE6
    assign od_clr     = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_CLEAR_OUTPUT), wmask);  // RULE6
    assign mask_set   = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_IRQ_ENABLE), wmask);    // RULE10
    assign mask_clr   = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_IRQ_DISABLE), wmask);
    assign pu_clr     = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_PULLUP_DISABLE), wmask); // RULE4
    assign pu_set     = wr_mask(wr & hit(ADR_I, pio_pkg::PIO_OFS_PULLUP_ENABLE), wmask);

    pio_bitreg #(.RESET_VALUE(pio_pkg::PIO_RST_PIN_ENABLE)) u_pin_en (
        .clk(CLK), .rst(RST), .set_mask(pin_en_set), .clr_mask(pin_en_clr), .q(pin_en_q)
    );
    pio_bitreg #(.RESET_VALUE(pio_pkg::PIO_RST_OUT_ENABLE)) u_oe (
        .clk(CLK), .rst(RST), .set_mask(oe_set), .clr_mask(oe_clr), .q(oe_q)
    );
    pio_bitreg #(.RESET_VALUE(pio_pkg::PIO_RST_OUT_DATA)) u_out (
        .clk(CLK), .rst(RST), .set_mask(od_set), .clr_mask(od_clr), .q(out_q)
    );
    pio_bitreg #(.RESET_VALUE(pio_pkg::PIO_RST_IRQ_MASK)) u_mask (
        .clk(CLK), .rst(RST), .set_mask(mask_set), .clr_mask(mask_clr), .q(mask_q)
    );
    // Pull-ups reset on; output straight from this flop
    pio_bitreg #(.RESET_VALUE(pio_pkg::PIO_RST_PULLUP)) u_pullup (
        .clk(CLK), .rst(RST), .set_mask(pu_set), .clr_mask(pu_clr), .q(pullup_q)
    ); // RULE3

    assign PULLUP_EN = pullup_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Pad muxing and sampling

    // Peripheral path gains one flop so every pad output is registered
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pad_out_r <= pio_pkg::PIO_RST_ZERO;
            pad_oe_r  <= pio_pkg::PIO_RST_ZERO;
        end else begin
            pad_out_r <= (pin_en_q & out_q) | (~pin_en_q & PERIPH_OUT); // RULE1
            pad_oe_r  <= (pin_en_q & oe_q) | (~pin_en_q & PERIPH_OE);   // RULE5
        end
    end

    assign PAD_OUT = pad_out_r;
    assign PAD_OE  = pad_oe_r;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            // Reset to the pulled-up idle level, so no false change follows reset
            pin_level_r <= pio_pkg::PIO_RST_PIN_LEVEL;
        end else begin
            pin_level_r <= PAD_IN; // RULE7
        end
    end

    assign PERIPH_IN = pin_level_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Change detection

    // Detection runs on all pins, whatever their owner
    genvar gi;
    generate
        for (gi = 0; gi < pio_pkg::PIO_WIDTH; gi++) begin : g_change
            assign change_evt[gi] = PAD_IN[gi] ^ pin_level_r[gi]; // RULE9
            // A change in the clearing cycle survives the read
            assign change_nxt[gi] = change_evt[gi] | (change_r[gi] & ~clr_status); // RULE11
        end
    endgenerate

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            change_r <= pio_pkg::PIO_RST_ZERO;
        end else begin
            change_r <= change_nxt; // RULE12
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(change_r & mask_q); // RULE8 RULE13
        end
    end

    assign IRQ = irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge

    always_comb begin
        rd_data = 32'h0000_0000;
        case (ADR_I[7:2])
            pio_pkg::PIO_OFS_PIN_STATUS[7:2]:    rd_data = pin_en_q;
            pio_pkg::PIO_OFS_OUT_STATUS[7:2]:    rd_data = oe_q;
            pio_pkg::PIO_OFS_OUT_DATA[7:2]:      rd_data = out_q;
            pio_pkg::PIO_OFS_PIN_LEVEL[7:2]:     rd_data = pin_level_r; // RULE2
            pio_pkg::PIO_OFS_IRQ_MASK[7:2]:      rd_data = mask_q;
            pio_pkg::PIO_OFS_CHANGE_STATUS[7:2]: rd_data = change_r;    // RULE11
            pio_pkg::PIO_OFS_PULLUP_STATUS[7:2]: rd_data = pullup_q;
            default:                             rd_data = 32'h0000_0000;
        endcase
    end

    // Every access, mapped or not, gets one ack a cycle after the request
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dat_r <= pio_pkg::PIO_RST_ZERO;
        end else if (rd) begin
            dat_r <= rd_data;
        end
    end

    assign ACK_O = ack_r;
    assign DAT_O = dat_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_ack_once;
        req |=> ACK_O ##1 !ACK_O;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

    property p_pin_enable;
        (pin_en_set != 32'h0000_0000) |=> ((pin_en_q & $past(pin_en_set)) == $past(pin_en_set));
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin enable lost"); // RULE1

    property p_generic_drive;
        ##1 (pin_en_q == $past(pin_en_q)) |=> ((PAD_OUT & $past(pin_en_q))
            == ($past(out_q) & $past(pin_en_q)));
    endproperty
    a_generic_drive: assert property (p_generic_drive) else $error("pad not out data"); // RULE2

    property p_pullup_reset;
        @(posedge CLK) $fell(RST) |-> (PULLUP_EN == pio_pkg::PIO_RST_PULLUP);
    endproperty
    a_pullup_reset: assert property (p_pullup_reset) else $error("pullups off at reset"); // RULE3

    property p_pullup_only_written;
        ##1 ((~PULLUP_EN & $past(PULLUP_EN) & ~$past(pu_clr)) == 32'h0000_0000);
    endproperty
    a_pullup_only_written: assert property (p_pullup_only_written) // RULE4
        else $error("pullup dropped without write");

    property p_out_enable;
        (oe_set != 32'h0000_0000) |=> ((oe_q & $past(oe_set)) == $past(oe_set))
            ##1 ((PAD_OE & $past(oe_set, 2) & $past(pin_en_q))
                 == ($past(oe_set, 2) & $past(pin_en_q)));
    endproperty
    a_out_enable: assert property (p_out_enable) else $error("output enable failed"); // RULE5

    property p_clear_output;
        (od_clr != 32'h0000_0000) |=> ((out_q & $past(od_clr)) == 32'h0000_0000);
    endproperty
    a_clear_output: assert property (p_clear_output) else $error("clear output failed"); // RULE6

    property p_set_output;
        (od_set != 32'h0000_0000) |=> ((out_q & $past(od_set)) == $past(od_set));
    endproperty
    a_set_output: assert property (p_set_output) else $error("set output failed"); // RULE6

    property p_irq_enable;
        (mask_set != 32'h0000_0000) |=> ((mask_q & $past(mask_set)) == $past(mask_set));
    endproperty
    a_irq_enable: assert property (p_irq_enable) else $error("irq enable lost"); // RULE10

    property p_level_read;
        (rd && hit(ADR_I, pio_pkg::PIO_OFS_PIN_LEVEL)) |=> (DAT_O == $past(PAD_IN, 2));
    endproperty
    a_level_read: assert property (p_level_read) else $error("pin level read wrong"); // RULE7

    property p_change_capture;
        (change_evt != 32'h0000_0000) |=> ((change_r & $past(change_evt)) == $past(change_evt));
    endproperty
    a_change_capture: assert property (p_change_capture) else $error("change lost"); // RULE9

    property p_irq_raise;
        (|(change_r & mask_q)) |=> IRQ;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("irq not raised"); // RULE8

    property p_irq_quiet;
        (!(|(change_r & mask_q))) |=> !IRQ;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq from disabled pin"); // RULE8

    property p_irq_hold;
        (IRQ && !$past(clr_status) && (mask_q == $past(mask_q))) |=> IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early"); // RULE13

    property p_status_clear;
        (clr_status && change_evt == 32'h0000_0000) |=> (DAT_O == $past(change_r))
            && (change_r == 32'h0000_0000) ##1 !IRQ;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared"); // RULE12

    c_irq_rise:    cover property ($rose(IRQ));
    c_status_ack:  cover property (IRQ && clr_status ##2 !IRQ);
    c_both_edges:  cover property ($rose(pin_level_r[0]) ##[1:20] $fell(pin_level_r[0]));
    c_peripheral:  cover property (pin_en_q != 32'hFFFF_FFFF && PERIPH_OE != 32'h0000_0000);

endmodule

`default_nettype wire

// *** test/pio_pin_model.sv ***
// Pin-side model: LEDs see the pin level, buttons pull their pin to ground.
// Assumes buttons change just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module pio_pin_model (
    // Clock
    input  wire logic        clk,
    // Pad controls from the controller
    input  wire logic [31:0] pad_out,
    input  wire logic [31:0] pad_oe,
    input  wire logic [31:0] pullup_en,
    // Buttons, high while pressed
    input  wire logic [31:0] button,
    // Pin levels
    output logic      [31:0] pad_in,
    output logic      [31:0] led_on
);
    logic [31:0] float_r = 32'h5555_5555;

    ////////////////////////////////////////////////////////////////////////////////
    // Floating pin keeps moving, so no lucky settled value passes
    always @(posedge clk) begin
        float_r <= ~float_r;
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (button[i])
                pad_in[i] = 1'b0;
            else if (pullup_en[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = float_r[i];
        end
    end

    assign led_on = pad_in;
endmodule

`default_nettype wire

// *** test/pio_ctrl_tb_top.sv ***
// Self-checking bench for the parallel I/O pin controller.
// Assumes the pin model beside it and a Wishbone master with idle gaps.
`timescale 1ns/10ps
`default_nettype none

module pio_ctrl_tb_top;
    logic        clk, rst, cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, dat_o, pad_in, pad_out, pad_oe, pullup_en;
    logic [31:0] periph_out, periph_oe, periph_in, button, rd;
    int          failures, checks_done;

    pio_ctrl pio_ctrl_inst (
        .CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PULLUP_EN(pullup_en),
        .PERIPH_OUT(periph_out), .PERIPH_OE(periph_oe), .PERIPH_IN(periph_in), .IRQ(irq)
    );
    pio_pin_model pio_pin_model_inst (
        .clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en),
        .button(button), .pad_in(pad_in), .led_on()
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; read data taken at the edge that sees ack
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            end_of_test();
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("irq raised", {31'h0, irq}, 32'h1);
        if (irq !== 1'b1) begin
            end_of_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("pullup port", pullup_en, 32'hFFFF_FFFF);
        chk("irq at reset", {31'h0, irq}, 32'h0);
        wb(1'b0, pio_pkg::PIO_OFS_PULLUP_STATUS, 32'h0);
        chk("pullup reg", rd, 32'hFFFF_FFFF);
        wb(1'b0, pio_pkg::PIO_OFS_PIN_STATUS, 32'h0);
        chk("pin status", rd, 32'h0000_0000);
        wb(1'b1, pio_pkg::PIO_OFS_PIN_LEVEL, 32'h0);
        wb(1'b0, pio_pkg::PIO_OFS_PIN_LEVEL, 32'h0);
        chk("level after write", rd, 32'hFFFF_FFFF);
        wb(1'b0, 8'hF0, 32'h0);
        chk("unmapped read", rd, 32'h0000_0000);
    endtask

    task automatic t_leds();
        wb(1'b1, pio_pkg::PIO_OFS_OUT_ENABLE, 32'h0000_0003);
        wb(1'b1, pio_pkg::PIO_OFS_PIN_ENABLE, 32'h0000_0003);
        wb(1'b1, pio_pkg::PIO_OFS_PULLUP_DISABLE, 32'h0000_0003);
        wb(1'b1, pio_pkg::PIO_OFS_SET_OUTPUT, 32'h0000_0001);
        settle();
        chk("pullup port", pullup_en, 32'hFFFF_FFFC);
        chk("led oe", pad_oe, 32'h0000_0003);
        chk("led out", pad_out, 32'h0000_0001);
        wb(1'b0, pio_pkg::PIO_OFS_PIN_LEVEL, 32'h0);
        chk("pin level", rd, 32'hFFFF_FFFD);
        wb(1'b1, pio_pkg::PIO_OFS_CLEAR_OUTPUT, 32'h0000_0001);
        wb(1'b1, pio_pkg::PIO_OFS_SET_OUTPUT, 32'h0000_0002);
        settle();
        chk("led swap", pad_out, 32'h0000_0002);
        wb(1'b0, pio_pkg::PIO_OFS_OUT_DATA, 32'h0);
        chk("out data", rd, 32'h0000_0002);
    endtask

    task automatic t_periph();
        @(posedge clk);
        periph_out <= 32'h0000_0061;
        periph_oe <= 32'h0000_0021;
        settle();
        chk("mixed oe", pad_oe, 32'h0000_0023);
        chk("mixed out", pad_out, 32'h0000_0062);
        chk("periph in", periph_in, pad_in);
        wb(1'b1, pio_pkg::PIO_OFS_PIN_DISABLE, 32'h0000_0002);
        settle();
        chk("handed back", pad_oe, 32'h0000_0021);
        // Pin 1 now floats; pull it up again so later change checks stay exact
        wb(1'b1, pio_pkg::PIO_OFS_PULLUP_ENABLE, 32'h0000_0002);
        settle();
        chk("pullup back", pullup_en, 32'hFFFF_FFFE);
        @(posedge clk);
        periph_oe <= 32'h0;
    endtask

    task automatic t_buttons();
        wb(1'b1, pio_pkg::PIO_OFS_PIN_ENABLE, 32'h0000_0300);
        wb(1'b1, pio_pkg::PIO_OFS_OUT_DISABLE, 32'h0000_0300);
        wb(1'b1, pio_pkg::PIO_OFS_IRQ_ENABLE, 32'h0000_0100);
        wb(1'b0, pio_pkg::PIO_OFS_IRQ_MASK, 32'h0);
        chk("irq mask", rd, 32'h0000_0100);
        wb(1'b0, pio_pkg::PIO_OFS_CHANGE_STATUS, 32'h0);
        settle();
        chk("quiet irq", {31'h0, irq}, 32'h0);
        @(posedge clk);
        button <= 32'h0000_0100;
        wait_irq();
        repeat (8) @(posedge clk);
        #1;
        chk("irq held", {31'h0, irq}, 32'h1);
        wb(1'b0, pio_pkg::PIO_OFS_CHANGE_STATUS, 32'h0);
        chk("press status", rd, 32'h0000_0100);
        #1;
        chk("irq acked", {31'h0, irq}, 32'h0);
        wb(1'b0, pio_pkg::PIO_OFS_PIN_LEVEL, 32'h0);
        chk("pressed level", rd & 32'h0000_0300, 32'h0000_0200);
        @(posedge clk);
        button <= 32'h0;
        wait_irq();
        wb(1'b0, pio_pkg::PIO_OFS_CHANGE_STATUS, 32'h0);
        chk("release status", rd, 32'h0000_0100);
        @(posedge clk);
        button <= 32'h0000_0200;
        settle();
        chk("masked pin", {31'h0, irq}, 32'h0);
        wb(1'b0, pio_pkg::PIO_OFS_CHANGE_STATUS, 32'h0);
        chk("masked status", rd, 32'h0000_0200);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock runs from time zero, before any access
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        periph_out = 32'h0;
        periph_oe = 32'h0;
        button = 32'h0;
        failures = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_leds();
        t_periph();
        t_buttons();
        end_of_test();
    end
endmodule

`default_nettype wire
